// *** core/deint_pkg.sv ***
`default_nettype none
package deint_pkg;
  // Data widths
  localparam int unsigned PIX_W = 24;
  localparam int unsigned WORD_W = 128;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SYNC_STAGES = 3;

  // Deinterlacing schemes selectable at build time
  typedef enum logic [1:0] {
    weave_scheme = 2'h0,
    line_interpolation_scheme = 2'h1,
    motion_adaptive_scheme = 2'h2
  } scheme_type;

  // Reader states
  typedef enum logic {
    rd_idle,
    rd_line
  } rd_state_type;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] FRAMES_OFFSET = 8'h08;

  // Field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STAT_IN_OVR_BIT = 0;
  localparam int unsigned STAT_OUT_OVR_BIT = 1;
  localparam int unsigned STAT_A_BIT = 2;
  localparam int unsigned STAT_B_BIT = 3;
  localparam int unsigned STAT_BUSY_BIT = 4;

  // Reset values
  localparam logic CTRL_RUN_RESET = 1'h1;

  // Longest tolerated output starvation
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned STARVE_TIME_NS = 320;
  localparam int unsigned STARVE_CYCLES = (STARVE_TIME_NS * 1000) / CLK_PERIOD_PS;

  // Bits taken by n pixels of 24 bits
  function automatic logic [20:0] pix_bits(input logic [15:0] n);
    pix_bits = 21'({n, 4'h0}) + 21'({n, 3'h0});
  endfunction : pix_bits
endpackage : deint_pkg
`default_nettype wire

// *** core/pixel_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module pixel_capture import deint_pkg::*; (
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // Interlaced input pins
  input wire logic pixin_clk,
  input wire logic [PIX_W-1:0] pixin,
  input wire logic pixin_field,
  input wire logic pixin_vsync,
  input wire logic pixin_val,
  // Captured pixel on the system clock
  output logic cap_stb,
  output logic [PIX_W-1:0] cap_pix,
  output logic cap_field,
  output logic cap_vsync
);
  localparam int unsigned LW = PIX_W + 3;

  logic [SYNC_STAGES-1:0] clk_s_q;
  logic [LW-1:0] d0_q;
  logic [LW-1:0] d1_q;
  logic [LW-1:0] d2_q;
  logic lvl_q;
  logic agreed;
  logic fall;

  // Link clock change counts once stages two and three agree
  assign agreed = clk_s_q[1] == clk_s_q[2];
  // Falling edge: data launched at the last rising edge is mid-eye here
  assign fall = agreed & lvl_q & ~clk_s_q[2];

  // Three-stage synchronisers for clock and pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_s_q <= '0;
      d0_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      clk_s_q <= {clk_s_q[1:0], pixin_clk};
      d0_q <= {pixin_val, pixin_vsync, pixin_field, pixin};
      d1_q <= d0_q;
      d2_q <= d1_q;
      if (agreed) begin
        lvl_q <= clk_s_q[2];
      end
    end
  end

  // One strobe per qualified input pixel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_stb <= 1'b0;
      cap_pix <= '0;
      cap_field <= 1'b0;
      cap_vsync <= 1'b0;
    end else begin
      cap_stb <= fall & d2_q[LW-1];
      if (fall) begin
        cap_pix <= d2_q[PIX_W-1:0];
        cap_field <= d2_q[PIX_W];
        cap_vsync <= d2_q[PIX_W+1];
      end
    end
  end
endmodule : pixel_capture
`default_nettype wire

// *** core/video_deinterlacer_frame_buffer.sv ***
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module video_deinterlacer_frame_buffer import deint_pkg::*; #(
  parameter scheme_type scheme = weave_scheme,
  parameter logic [ADDR_W-1:0] buffer_a_base = 32'h0000_0000,
  parameter logic [ADDR_W-1:0] buffer_b_base = 32'h0010_0000,
  parameter bit frame_repeat = 1'b1,
  parameter bit field_polarity = 1'b0
) (
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Format
  input wire logic [15:0] pixels_per_line,
  input wire logic [15:0] lines_per_field,
  input wire logic [31:0] words_per_field,
  // Interlaced input
  input wire logic pixin_clk,
  input wire logic [PIX_W-1:0] pixin,
  input wire logic pixin_field,
  input wire logic pixin_vsync,
  input wire logic pixin_val,
  // Progressive output
  output logic [PIX_W-1:0] pixout,
  output logic pixout_vsync,
  output logic pixout_hsync,
  output logic pixout_val,
  input wire logic pixout_rdy,
  // Memory
  output logic mem_rw,
  output logic [WORD_W-1:0] mem_wdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_addr_val,
  input wire logic mem_addr_rdy,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_rdata_val,
  // Diagnostics
  output logic input_overrun_flag,
  output logic output_overrun_flag
);
  logic cap_stb;
  logic [PIX_W-1:0] cap_pix;
  logic cap_field;
  logic cap_vsync;

  pixel_capture u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .pixin_clk(pixin_clk),
    .pixin(pixin),
    .pixin_field(pixin_field),
    .pixin_vsync(pixin_vsync),
    .pixin_val(pixin_val),
    .cap_stb(cap_stb),
    .cap_pix(cap_pix),
    .cap_field(cap_field),
    .cap_vsync(cap_vsync)
  );

  // Every scheme stores fields alike; filtering is not modelled here
  localparam scheme_type SCHEME_SEL = scheme;

  // ---------------- Register state ----------------
  logic run_q;
  logic [15:0] frames_q;
  logic ahb_wr_q;
  logic [7:0] ahb_addr_q;
  logic [1:0] valid_q;
  logic [1:0] new_q;
  logic hold_q;
  rd_state_type rd_state_q;

  // Bus decode
  logic ahb_go;
  logic ahb_wr_data;
  logic [31:0] rd_word;
  logic stat_clr_in;
  logic stat_clr_out;
  assign ahb_go = hsel & htrans[1] & hready;
  assign ahb_wr_data = ahb_wr_q & hready;
  assign stat_clr_in = ahb_wr_data & (ahb_addr_q == STATUS_OFFSET) & hwdata[STAT_IN_OVR_BIT];
  assign stat_clr_out = ahb_wr_data & (ahb_addr_q == STATUS_OFFSET) & hwdata[STAT_OUT_OVR_BIT];
  assign rd_word = (haddr[7:0] == CTRL_OFFSET) ? {31'h0, run_q} :
                   (haddr[7:0] == STATUS_OFFSET) ? {27'h0, rd_state_q == rd_line, valid_q,
                                                    output_overrun_flag, input_overrun_flag} :
                   (haddr[7:0] == FRAMES_OFFSET) ? {16'h0, frames_q} : 32'h0;

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_q <= 1'b0;
      ahb_addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      run_q <= CTRL_RUN_RESET;
    end else begin
      ahb_wr_q <= ahb_go & hwrite;
      if (ahb_go) begin
        ahb_addr_q <= haddr[7:0];
        hrdata <= hwrite ? 32'h0 : rd_word;
      end
      if (ahb_wr_data & (ahb_addr_q == CTRL_OFFSET)) begin
        run_q <= hwdata[CTRL_RUN_BIT];
      end
    end
  end

  // ---------------- Field writer ----------------
  logic wr_active_q;
  logic wr_buf_q;
  logic [31:0] wr_cnt_q;
  logic [151:0] pk_acc_q;
  logic [7:0] pk_fill_q;
  logic wq_val_q;
  logic [WORD_W-1:0] wq_data_q;
  logic [ADDR_W-1:0] wq_addr_q;
  logic rd_busy;

  logic field_par;
  logic start;
  logic take;
  logic [151:0] pk_in;
  logic [7:0] pk_fill_in;
  logic emit;
  logic req_free;
  logic wq_go;
  logic wq_drop;
  logic field_done;
  assign field_par = cap_field ^ field_polarity;
  assign start = cap_stb & cap_vsync;
  assign take = cap_stb & (start ? ~rd_busy : wr_active_q);
  assign pk_in = start ? 152'(cap_pix) : (pk_acc_q | (152'(cap_pix) << pk_fill_q));
  assign pk_fill_in = start ? 8'(PIX_W) : pk_fill_q + 8'(PIX_W);
  assign emit = take & (pk_fill_in >= 8'(WORD_W));
  assign req_free = ~mem_addr_val | mem_addr_rdy;
  assign wq_go = req_free & wq_val_q;
  assign wq_drop = emit & wq_val_q & ~wq_go;
  assign field_done = emit & (wr_cnt_q + 32'h1 == words_per_field);

  // Pack pixels densely into 128-bit words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_active_q <= 1'b0;
      wr_buf_q <= 1'b0;
      wr_cnt_q <= 32'h0;
      pk_acc_q <= '0;
      pk_fill_q <= 8'h00;
    end else begin
      if (take) begin
        pk_acc_q <= emit ? (pk_in >> WORD_W) : pk_in;
        pk_fill_q <= emit ? pk_fill_in - 8'(WORD_W) : pk_fill_in;
      end
      if (start) begin
        wr_active_q <= ~rd_busy;
        wr_buf_q <= field_par;
        wr_cnt_q <= 32'h0;
      end else if (emit) begin
        wr_cnt_q <= wr_cnt_q + 32'h1;
        wr_active_q <= ~field_done;
      end
    end
  end

  // One-word write holding stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wq_val_q <= 1'b0;
      wq_data_q <= '0;
      wq_addr_q <= 32'h0;
    end else if (emit & ~wq_drop) begin
      wq_val_q <= 1'b1;
      wq_data_q <= pk_in[WORD_W-1:0];
      wq_addr_q <= (wr_buf_q ? buffer_b_base : buffer_a_base) + wr_cnt_q;
    end else if (wq_go) begin
      wq_val_q <= 1'b0;
    end
  end

  // ---------------- Frame reader ----------------
  logic rd_pend_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [16:0] ln_q;
  logic [38:0] off_q;
  logic [6:0] skip_q;
  logic first_q;
  logic [15:0] px_left_q;
  logic [255:0] ua_q;
  logic [8:0] ua_fill_q;
  logic [15:0] starve_q;

  logic rd_start;
  logic rd_want;
  logic rd_go;
  logic pop;
  logic line_end;
  logic frame_end;
  logic line_load;
  logic [16:0] ln_next;
  logic [38:0] off_next;
  logic [255:0] ua_pop;
  logic [8:0] fill_pop;
  assign rd_start = (rd_state_q == rd_idle) & run_q & ~wr_active_q & ~hold_q &
                    ((&new_q) | (frame_repeat & (&valid_q)));
  assign rd_busy = (rd_state_q == rd_line) | rd_start;
  assign rd_want = (rd_state_q == rd_line) & ~rd_pend_q & ~first_q | (rd_state_q == rd_line) & first_q & ~rd_pend_q;
  assign rd_go = req_free & ~wq_val_q & rd_want & (ua_fill_q <= 9'(WORD_W)) &
                 (pix_bits(px_left_q) > 21'(ua_fill_q));
  assign pop = (rd_state_q == rd_line) & (~pixout_val | pixout_rdy) &
               (ua_fill_q >= 9'(PIX_W)) & (px_left_q != 16'h0);
  assign line_end = pop & (px_left_q == 16'h1);
  assign frame_end = line_end & (ln_q == {lines_per_field, 1'b0} - 17'h1);
  assign line_load = rd_start | (line_end & ~frame_end);
  assign ln_next = rd_start ? 17'h0 : ln_q + 17'h1;
  assign off_next = rd_start ? 39'h0 :
                    (ln_q[0] ? off_q + 39'(pix_bits(pixels_per_line)) : off_q);
  assign ua_pop = pop ? (ua_q >> PIX_W) : ua_q;
  assign fill_pop = pop ? ua_fill_q - 9'(PIX_W) : ua_fill_q;

  // Reader sequencing over lines of both fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_state_q <= rd_idle;
      ln_q <= 17'h0;
      off_q <= 39'h0;
      rd_addr_q <= 32'h0;
      skip_q <= 7'h00;
      px_left_q <= 16'h0;
      frames_q <= 16'h0;
    end else begin
      if (rd_start) begin
        rd_state_q <= rd_line;
      end else if (frame_end) begin
        rd_state_q <= rd_idle;
        frames_q <= frames_q + 16'h1;
      end
      if (line_load) begin
        ln_q <= ln_next;
        off_q <= off_next;
        rd_addr_q <= (ln_next[0] ? buffer_b_base : buffer_a_base) + off_next[38:7];
        skip_q <= off_next[6:0];
        px_left_q <= pixels_per_line;
      end else begin
        if (rd_go) begin
          rd_addr_q <= rd_addr_q + 32'h1;
        end
        if (pop) begin
          px_left_q <= px_left_q - 16'h1;
        end
      end
    end
  end

  // Unpack read words into pixels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ua_q <= '0;
      ua_fill_q <= 9'h000;
      first_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      if (rd_go) begin
        rd_pend_q <= 1'b1;
      end else if (mem_rdata_val) begin
        rd_pend_q <= 1'b0;
      end
      if (line_load) begin
        ua_q <= '0;
        ua_fill_q <= 9'h000;
        first_q <= 1'b1;
      end else if (mem_rdata_val & rd_pend_q) begin
        first_q <= 1'b0;
        ua_q <= first_q ? 256'(mem_rdata >> skip_q) : (ua_pop | (256'(mem_rdata) << fill_pop));
        ua_fill_q <= first_q ? 9'(WORD_W) - 9'(skip_q) : fill_pop + 9'(WORD_W);
      end else begin
        ua_q <= ua_pop;
        ua_fill_q <= fill_pop;
      end
    end
  end

  // Output pixel register on the system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pixout_val <= 1'b0;
      pixout <= '0;
      pixout_vsync <= 1'b0;
      pixout_hsync <= 1'b0;
    end else if (pop) begin
      pixout_val <= 1'b1;
      pixout <= ua_q[PIX_W-1:0];
      pixout_hsync <= px_left_q == pixels_per_line;
      pixout_vsync <= (px_left_q == pixels_per_line) & (ln_q == 17'h0);
    end else if (pixout_rdy) begin
      pixout_val <= 1'b0;
    end
  end

  // Memory request port, writes first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_addr_val <= 1'b0;
      mem_rw <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= '0;
    end else if (wq_go) begin
      mem_addr_val <= 1'b1;
      mem_rw <= 1'b0;
      mem_addr <= wq_addr_q;
      mem_wdata <= wq_data_q;
    end else if (rd_go) begin
      mem_addr_val <= 1'b1;
      mem_rw <= 1'b1;
      mem_addr <= rd_addr_q;
    end else if (mem_addr_rdy) begin
      mem_addr_val <= 1'b0;
    end
  end

  // Field bookkeeping, hold after a skipped field, error flags
  logic starve_hit;
  assign starve_hit = starve_q == 16'(STARVE_CYCLES);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_q <= 2'b00;
      new_q <= 2'b00;
      hold_q <= 1'b0;
      starve_q <= 16'h0;
      input_overrun_flag <= 1'b0;
      output_overrun_flag <= 1'b0;
    end else begin
      if (start & ~rd_busy) begin
        valid_q[field_par] <= 1'b0;
        new_q[field_par] <= 1'b0;
      end else if (field_done) begin
        valid_q[wr_buf_q] <= 1'b1;
        new_q[wr_buf_q] <= 1'b1;
      end else if (rd_start) begin
        new_q <= 2'b00;
      end
      if (start) begin
        hold_q <= rd_busy;
      end
      if ((rd_state_q == rd_line) & ~pixout_val & pixout_rdy & ~starve_hit) begin
        starve_q <= starve_q + 16'h1;
      end else if (~((rd_state_q == rd_line) & ~pixout_val & pixout_rdy)) begin
        starve_q <= 16'h0;
      end
      input_overrun_flag <= wq_drop | (input_overrun_flag & ~stat_clr_in);
      output_overrun_flag <= starve_hit | (output_overrun_flag & ~stat_clr_out);
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_req_held: assert property (mem_addr_val & ~mem_addr_rdy |=>
    mem_addr_val & $stable(mem_addr) & $stable(mem_rw) & $stable(mem_wdata))
    else $error("memory request changed before acceptance");
  a_out_hold: assert property (pixout_val & ~pixout_rdy |=>
    pixout_val & $stable(pixout) & $stable(pixout_vsync) & $stable(pixout_hsync))
    else $error("output pixel changed while stalled");
  a_vsync_line: assert property (pixout_val & pixout_vsync |-> pixout_hsync)
    else $error("frame start without line start");
  a_read_dir: assert property (mem_addr_val & mem_addr_rdy & mem_rw |=> rd_pend_q)
    else $error("accepted read not tracked");
  a_rdata_gate: assert property ((rd_state_q == rd_line) & ~mem_rdata_val & ~line_load
    |=> ua_fill_q <= $past(ua_fill_q))
    else $error("unpacker grew without read data");
  a_in_ovr: assert property (wq_drop |=> input_overrun_flag[*2])
    else $error("lost input word not flagged");
  a_out_ovr: assert property ($rose(output_overrun_flag) |-> $past(starve_hit))
    else $error("output overrun without starvation");
  a_no_tear: assert property ((rd_state_q == rd_line) |-> ~wr_active_q)
    else $error("field written while frame is read");
  a_xfer_once: assert property (pixout_val & pixout_rdy & ~pop |=> ~pixout_val)
    else $error("pixel repeated after transfer");

  c_frame_out: cover property (pixout_val & pixout_rdy & pixout_vsync);
  c_in_ovr: cover property ($rose(input_overrun_flag));
  c_read_acc: cover property (mem_addr_val & mem_addr_rdy & mem_rw);
  c_repeat: cover property (rd_start & ~(&new_q));
endmodule : video_deinterlacer_frame_buffer
`default_nettype wire

// *** verification/mem_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module mem_partner import deint_pkg::*; (
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // Requests
  input wire logic mem_rw,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_addr_val,
  output logic mem_addr_rdy,
  // Read return
  output logic [WORD_W-1:0] mem_rdata,
  output logic mem_rdata_val,
  // Read latency in cycles
  input wire logic [7:0] rd_lat
);
  logic [WORD_W-1:0] store [logic [ADDR_W-1:0]];
  logic [WORD_W-1:0] rq [$];
  logic [7:0] wait_q;
  logic [1:0] tick_q;
  // Refuse one request cycle in four
  assign mem_addr_rdy = |tick_q;
  // Take requests, return reads in order after the latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 2'h0;
      wait_q <= 8'h0;
      mem_rdata_val <= 1'b0;
      mem_rdata <= '0;
      rq.delete();
    end else begin
      tick_q <= tick_q + 2'h1;
      mem_rdata_val <= 1'b0;
      mem_rdata <= ~mem_rdata; // Idle data keeps moving
      if (mem_addr_val && mem_addr_rdy && !mem_rw) begin
        store[mem_addr] = mem_wdata;
      end
      if (mem_addr_val && mem_addr_rdy && mem_rw) begin
        rq.push_back(store.exists(mem_addr) ? store[mem_addr] : ~'0);
      end
      if (rq.size() > 0 && wait_q >= rd_lat) begin
        mem_rdata <= rq.pop_front();
        mem_rdata_val <= 1'b1;
        wait_q <= 8'h0;
      end else if (rq.size() > 0) begin
        wait_q <= wait_q + 8'h1;
      end
    end
  end
endmodule : mem_partner
`default_nettype wire

// *** verification/video_deinterlacer_frame_buffer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_deinterlacer_frame_buffer_tb_top import deint_pkg::*;;
  localparam int PPL = 16;
  localparam int WPF = 6;
  localparam int FPIX = 32;
  localparam logic [31:0] BASE_A = 32'h0000_0040;
  localparam logic [31:0] BASE_B = 32'h0000_0200;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pixout_rdy, sink_slow;
  logic pixin_clk, pixin_field, pixin_vsync, pixin_val, pixout_vsync, pixout_hsync, pixout_val;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, rdy_cnt;
  logic [2:0] hsize;
  logic [PIX_W-1:0] pixin, pixout;
  logic mem_rw, mem_addr_val, mem_addr_rdy, mem_rdata_val, input_overrun_flag, output_overrun_flag;
  logic [WORD_W-1:0] mem_wdata, mem_rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0] rd_lat;
  logic [25:0] got [$];
  int miscompares, checks;

  video_deinterlacer_frame_buffer #(.scheme(weave_scheme), .buffer_a_base(BASE_A), .buffer_b_base(BASE_B),
    .frame_repeat(1'b1), .field_polarity(1'b0)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pixels_per_line(16'(PPL)),
    .lines_per_field(16'h0002), .words_per_field(32'(WPF)), .pixin_clk(pixin_clk), .pixin(pixin),
    .pixin_field(pixin_field), .pixin_vsync(pixin_vsync), .pixin_val(pixin_val), .pixout(pixout),
    .pixout_vsync(pixout_vsync), .pixout_hsync(pixout_hsync), .pixout_val(pixout_val),
    .pixout_rdy(pixout_rdy), .mem_rw(mem_rw), .mem_wdata(mem_wdata), .mem_addr(mem_addr),
    .mem_addr_val(mem_addr_val), .mem_addr_rdy(mem_addr_rdy), .mem_rdata(mem_rdata),
    .mem_rdata_val(mem_rdata_val), .input_overrun_flag(input_overrun_flag),
    .output_overrun_flag(output_overrun_flag));
  mem_partner u_mem (.hclk(hclk), .hresetn(hresetn), .mem_rw(mem_rw), .mem_wdata(mem_wdata),
    .mem_addr(mem_addr), .mem_addr_val(mem_addr_val), .mem_addr_rdy(mem_addr_rdy),
    .mem_rdata(mem_rdata), .mem_rdata_val(mem_rdata_val), .rd_lat(rd_lat));

  // System clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Sink stalls one cycle in four when slow
  always @(posedge hclk) begin
    rdy_cnt <= rdy_cnt + 2'h1;
    pixout_rdy <= !sink_slow || rdy_cnt != 2'h0;
  end
  // Collect transferred pixels
  always @(posedge hclk) begin
    if (pixout_val === 1'b1 && pixout_rdy === 1'b1) got.push_back({pixout_vsync, pixout_hsync, pixout});
  end

  task automatic check(input logic [127:0] g, input logic [127:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic timed_out();
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    miscompares++;
    finish_test();
  endtask : timed_out
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) timed_out();
      @(posedge hclk);
    end
  endtask : wait_ready
  // One AHB single word transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rv);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rv = hrdata;
  endtask : bus
  task automatic wait_pix(input int n);
    for (int i = 0; got.size() < n; i++) begin
      if (i > 40000) timed_out();
      @(posedge hclk);
    end
  endtask : wait_pix
  function automatic logic [23:0] pv(input logic f, input int i);
    pv = {4'h5, 3'h0, f, 8'h3c, 8'(i)};
  endfunction : pv
  // One link clock period, data launched after the rising edge
  task automatic link(input logic [23:0] p, input logic f, input logic vs, input logic v);
    pixin_clk = 1'b1;
    #1;
    pixin = p;
    pixin_field = f;
    pixin_vsync = vs;
    pixin_val = v;
    #61.5 pixin_clk = 1'b0;
    #62.5;
  endtask : link
  // Whole field, with idle junk slots between pixels
  task automatic send_field(input logic f);
    for (int i = 0; i < FPIX; i++) begin
      link(pv(f, i), f, i == 0, 1'b1);
      if (i % 8 == 3) link(~pv(f, i), ~f, 1'b1, 1'b0);
    end
    pixin_val = 1'b0;
    pixin = ~pixin;
  endtask : send_field

  initial begin
    logic [143:0] w;
    logic [31:0] exp_reg [4];
    int l;
    {hresetn, hsel, hwrite, pixin_clk, pixin_field, pixin_vsync, pixin_val, sink_slow} = 8'h01;
    {haddr, hwdata, htrans, hsize, pixin, rd_lat, rdy_cnt} = '0;
    miscompares = 0;
    checks = 0;
    exp_reg = '{32'h1, 32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    check(hresp, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0 == 1'b1, 32'(i * 4), 32'h0, rd);
      check(rd, exp_reg[i]);
    end
    bus(1'b1, 32'(CTRL_OFFSET), 32'h0, rd);
    bus(1'b0, 32'(CTRL_OFFSET), 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, 32'(CTRL_OFFSET), 32'h1, rd);
    link(24'h123456, 1'b1, 1'b0, 1'b1);
    send_field(1'b1);
    send_field(1'b0);
    wait_pix(4 * PPL);
    for (int k = 0; k < 4 * PPL; k++) begin
      l = k / PPL;
      check(got[k], {k == 0, k % PPL == 0, pv(1'(l % 2), (l / 2) * PPL + k % PPL)});
    end
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 6; i++) w[i * 24 +: 24] = pv(f[0], i);
      check(u_mem.store[f != 0 ? BASE_B : BASE_A], w[127:0]);
    end
    bus(1'b0, 32'(STATUS_OFFSET), 32'h0, rd);
    check(rd & 32'h1f, 32'h1c);
    bus(1'b0, 32'(FRAMES_OFFSET), 32'h0, rd);
    check(rd, 32'h1);
    rd_lat <= 8'd100;
    sink_slow <= 1'b0;
    send_field(1'b0);
    for (int i = 0; output_overrun_flag !== 1'b1; i++) begin
      if (i > 40000) timed_out();
      @(posedge hclk);
    end
    rd_lat <= 8'd0;
    wait_pix(8 * PPL);
    bus(1'b0, 32'(STATUS_OFFSET), 32'h0, rd);
    check(rd[1], 1'b1);
    bus(1'b1, 32'(STATUS_OFFSET), 32'h2, rd);
    bus(1'b0, 32'(STATUS_OFFSET), 32'h0, rd);
    check({rd[1], output_overrun_flag, input_overrun_flag}, 3'h0);
    bus(1'b0, 32'(FRAMES_OFFSET), 32'h0, rd);
    check(rd, 32'h2);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check({pixout_val, mem_addr_val, output_overrun_flag, hreadyout}, 4'h1);
    hresetn <= 1'b1;
    bus(1'b0, 32'(FRAMES_OFFSET), 32'h0, rd);
    check(rd, 32'h0);
    finish_test();
  end
endmodule : video_deinterlacer_frame_buffer_tb_top
`default_nettype wire
